// ==== hdl/ufm_dma_req.sv ====
/*
 * One DMA request generator: picks the mode zero or mode one condition
 * and drives an active-low request from a flip-flop.
 * Assumes both conditions come from logic on the same clock.
 */
`timescale 1ns/100ps
module ufm_dma_req (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Conditions
  input wire logic mode,
  input wire logic cond_mode0,
  input wire logic cond_mode1,
  // Request
  output logic req_n_q
);

  logic req_n_d;

  assign req_n_d = (mode == ufm_pkg::UFM_DMA_MODE1) ? !cond_mode1
                                                    : !cond_mode0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_n_q <= 1'b1;
    end else begin
      req_n_q <= req_n_d;
    end
  end

endmodule

// ==== hdl/ufm_mirror_top.sv ====
/*
 * Queue control mirror block for the second serial port: three APB
 * mirror registers that each update one field of the queue control
 * register, the queue enable and queue reset outputs, the receive data
 * available flag, both DMA request outputs and a masked interrupt.
 * Assumes queue fill levels come from logic on pclk, and that the APB
 * master follows the usual setup and access phases.
 */
// Our own choice: register access over APB.
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - DMA mirror write updates queue control bit 3.
// - DMA bit selects request signalling mode.
// - Mirror write changes only its own field.
// - Enable mirror write updates queue control bit 0.
// - Enable bit switches both queues together.
// - Enable falling resets both queue controllers.
// - Threshold mirror write updates bits 7 to 6.
// - Threshold field sets data available level while the enable bit is set.
// - In mode one, receive request follows the data available condition.
`timescale 1ns/100ps
module ufm_mirror_top #(
  parameter int DEPTH = 16,
  parameter int LW = $clog2(DEPTH) + 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Queue fill levels
  input wire logic [LW-1:0] tx_level,
  input wire logic [LW-1:0] rx_level,
  // Queue control
  output logic [ufm_pkg::UFM_QCR_W-1:0] queue_control,
  output logic tx_queue_enable,
  output logic rx_queue_enable,
  output logic queue_reset,
  output logic rx_data_avail,
  // DMA requests
  output logic dma_tx_req_n,
  output logic dma_rx_req_n,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;
  logic [ufm_pkg::UFM_QCR_W-1:0] qcr_q;
  logic [ufm_pkg::UFM_QCR_W-1:0] qcr_d;
  logic txen_q;
  logic rxen_q;
  logic qrst_q;
  logic qrst_d;
  logic rx_avail_q;
  logic rx_avail_d;
  logic [ufm_pkg::UFM_IRQ_W-1:0] stat_q;
  logic [ufm_pkg::UFM_IRQ_W-1:0] stat_d;
  logic [ufm_pkg::UFM_IRQ_W-1:0] mask_q;
  logic [ufm_pkg::UFM_IRQ_W-1:0] mask_d;
  logic irq_q;
  logic rx_hit_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.
  // The slave answers in the first access cycle: pready is raised by the
  // setup cycle, so every output stays a plain flip-flop.

  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire wr_en = access && pwrite;
  wire sel_dmam = (paddr == ufm_pkg::UFM_ADDR_DMA_MODE);
  wire sel_fe = (paddr == ufm_pkg::UFM_ADDR_Q_ENABLE);
  wire sel_rt = (paddr == ufm_pkg::UFM_ADDR_RX_THR);
  wire sel_stat = (paddr == ufm_pkg::UFM_ADDR_IRQ_STAT);
  wire sel_mask = (paddr == ufm_pkg::UFM_ADDR_IRQ_MASK);
  wire sel_view = (paddr == ufm_pkg::UFM_ADDR_QCR_VIEW);
  wire mapped = sel_dmam || sel_fe || sel_rt || sel_stat || sel_mask ||
                sel_view;
  wire wr_dmam = wr_en && sel_dmam;
  wire wr_fe = wr_en && sel_fe;
  wire wr_rt = wr_en && sel_rt;
  wire wr_stat = wr_en && sel_stat;
  wire wr_mask = wr_en && sel_mask;

  // Current field values as seen by the mirrors.
  wire fe_now = qcr_q[ufm_pkg::UFM_QCR_FE_BIT];
  wire dmam_now = qcr_q[ufm_pkg::UFM_QCR_DMAM_BIT];
  wire [1:0] rt_now = qcr_q[ufm_pkg::UFM_QCR_RT_MSB:ufm_pkg::UFM_QCR_RT_LSB];
  wire fe_wdata = pwdata[ufm_pkg::UFM_MIR_BIT];

  // Read mux; reserved bits above each field read as zero.
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (sel_dmam) begin
      prdata_d[ufm_pkg::UFM_MIR_BIT] = dmam_now;
    end else if (sel_fe) begin
      prdata_d[ufm_pkg::UFM_MIR_BIT] = fe_now;
    end else if (sel_rt) begin
      prdata_d[ufm_pkg::UFM_RT_W-1:0] = rt_now;
    end else if (sel_stat) begin
      prdata_d[ufm_pkg::UFM_IRQ_W-1:0] = stat_q;
    end else if (sel_mask) begin
      prdata_d[ufm_pkg::UFM_IRQ_W-1:0] = mask_q;
    end else if (sel_view) begin
      prdata_d[ufm_pkg::UFM_QCR_W-1:0] = qcr_q;
    end
  end

  assign pslverr_d = setup && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= setup && !pwrite ? prdata_d : 32'h0000_0000;
      pready_q <= setup;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue control register, updated one field at a time.

  always_comb begin
    qcr_d = qcr_q;
    if (wr_dmam) begin
      qcr_d[ufm_pkg::UFM_QCR_DMAM_BIT] = pwdata[ufm_pkg::UFM_MIR_BIT];
    end
    if (wr_fe) begin
      qcr_d[ufm_pkg::UFM_QCR_FE_BIT] = fe_wdata;
    end
    if (wr_rt) begin
      qcr_d[ufm_pkg::UFM_QCR_RT_MSB:ufm_pkg::UFM_QCR_RT_LSB] =
        pwdata[ufm_pkg::UFM_RT_W-1:0];
    end
  end

  assign qrst_d = wr_fe && fe_now && !fe_wdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcr_q <= ufm_pkg::UFM_QCR_RESET;
      qrst_q <= 1'b0;
    end else begin
      qcr_q <= qcr_d;
      qrst_q <= qrst_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txen_q <= 1'b0;
      rxen_q <= 1'b0;
    end else begin
      txen_q <= qcr_d[ufm_pkg::UFM_QCR_FE_BIT];
      rxen_q <= qcr_d[ufm_pkg::UFM_QCR_FE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive trigger, data available flag and DMA requests.

  logic rx_hit;

  ufm_rx_trigger #(
    .DEPTH(DEPTH),
    .LW(LW)
  ) u_rx_trigger (
    .level(rx_level),
    .trig_sel(rt_now),
    .hit(rx_hit)
  );

  // data available at threshold
  // Without the queues the holding register holds one character, so any
  // nonzero level counts as available.
  assign rx_avail_d = fe_now ? rx_hit : (rx_level != '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_avail_q <= 1'b0;
      rx_hit_q <= 1'b0;
    end else begin
      rx_avail_q <= rx_avail_d;
      rx_hit_q <= rx_avail_d;
    end
  end

  wire tx_empty = (tx_level == '0);
  wire tx_space = (tx_level < LW'(DEPTH));
  wire rx_nonempty = (rx_level != '0);

  ufm_dma_req u_tx_req (
    .pclk(pclk),
    .presetn(presetn),
    .mode(dmam_now),
    .cond_mode0(tx_empty),
    .cond_mode1(tx_space),
    .req_n_q(dma_tx_req_n)
  );

  ufm_dma_req u_rx_req (
    .pclk(pclk),
    .presetn(presetn),
    .mode(dmam_now),
    .cond_mode0(rx_nonempty),
    .cond_mode1(rx_avail_d),
    .req_n_q(dma_rx_req_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output.
  // A new event in the cycle of a write-one clear keeps its bit set.

  wire [ufm_pkg::UFM_IRQ_W-1:0] ev;
  wire [ufm_pkg::UFM_IRQ_W-1:0] clr;

  assign ev[ufm_pkg::UFM_IRQ_RX_BIT] = rx_avail_d && !rx_hit_q;
  assign ev[ufm_pkg::UFM_IRQ_QRST_BIT] = qrst_d;
  assign clr = wr_stat ? pwdata[ufm_pkg::UFM_IRQ_W-1:0] : '0;
  assign stat_d = (stat_q & ~clr) | ev;
  assign mask_d = wr_mask ? pwdata[ufm_pkg::UFM_IRQ_W-1:0] : mask_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= ufm_pkg::UFM_IRQ_RESET;
      mask_q <= ufm_pkg::UFM_IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= |(stat_d & mask_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign queue_control = qcr_q;
  assign tx_queue_enable = txen_q;
  assign rx_queue_enable = rxen_q;
  assign queue_reset = qrst_q;
  assign rx_data_avail = rx_avail_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_fe_fall;
    wr_fe && fe_now && !fe_wdata;
  endsequence

  sequence s_reset_pulse;
    queue_reset ##1 !queue_reset;
  endsequence

  property p_dmam_wr;
    wr_dmam |=> queue_control[ufm_pkg::UFM_QCR_DMAM_BIT] ==
                $past(pwdata[ufm_pkg::UFM_MIR_BIT]);
  endproperty
  a_dmam_wr: assert property (p_dmam_wr)
    else $error("DMA mode field did not follow mirror write");

  property p_mode_sel;
    (dmam_now && rx_level != '0 && !rx_avail_d) |=> dma_rx_req_n;
  endproperty
  a_mode_sel: assert property (p_mode_sel)
    else $error("Mode one receive request raised below threshold");

  property p_others_kept;
    (wr_fe && !wr_dmam && !wr_rt) |=>
      queue_control[ufm_pkg::UFM_QCR_RT_MSB:ufm_pkg::UFM_QCR_DMAM_BIT] ==
      $past(qcr_q[ufm_pkg::UFM_QCR_RT_MSB:ufm_pkg::UFM_QCR_DMAM_BIT]);
  endproperty
  a_others_kept: assert property (p_others_kept)
    else $error("Enable mirror write disturbed other fields");

  property p_fe_wr;
    wr_fe |=> queue_control[ufm_pkg::UFM_QCR_FE_BIT] == $past(fe_wdata);
  endproperty
  a_fe_wr: assert property (p_fe_wr)
    else $error("Enable field did not follow mirror write");

  property p_queues_together;
    wr_fe |=> (tx_queue_enable == $past(fe_wdata)) &&
              (rx_queue_enable == $past(fe_wdata));
  endproperty
  a_queues_together: assert property (p_queues_together)
    else $error("Queue enables did not switch together");

  property p_qrst;
    s_fe_fall |=> s_reset_pulse;
  endproperty
  a_qrst: assert property (p_qrst)
    else $error("Queue reset pulse missing after enable fall");

  property p_rt_wr;
    wr_rt |=> queue_control[ufm_pkg::UFM_QCR_RT_MSB:ufm_pkg::UFM_QCR_RT_LSB]
              == $past(pwdata[ufm_pkg::UFM_RT_W-1:0]);
  endproperty
  a_rt_wr: assert property (p_rt_wr)
    else $error("Trigger field did not follow mirror write");

  property p_half_avail;
    (fe_now && rt_now == ufm_pkg::UFM_TRIG_HALF &&
     rx_level == LW'(DEPTH / 2)) |=> rx_data_avail;
  endproperty
  a_half_avail: assert property (p_half_avail)
    else $error("Half full level did not flag data available");

  property p_rx_dma_m1;
    (dmam_now && rx_avail_d) |=> !dma_rx_req_n;
  endproperty
  a_rx_dma_m1: assert property (p_rx_dma_m1)
    else $error("Mode one receive request missing at threshold");

  property p_reserved_zero;
    (pready && !pwrite && (sel_dmam || sel_fe || sel_rt)) |->
      prdata[31:ufm_pkg::UFM_RT_W] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved mirror bits read nonzero");

endmodule

// ==== hdl/ufm_pkg.sv ====
/*
 * Shared constants for the queue control mirror block: register byte
 * addresses, queue control field positions, trigger encodings, reset
 * values and interrupt bit layout.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package ufm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [31:0] UFM_ADDR_DMA_MODE = 32'h5000_1194;
  localparam logic [31:0] UFM_ADDR_Q_ENABLE = 32'h5000_1198;
  localparam logic [31:0] UFM_ADDR_RX_THR = 32'h5000_119C;
  localparam logic [31:0] UFM_ADDR_IRQ_STAT = 32'h5000_11B0;
  localparam logic [31:0] UFM_ADDR_IRQ_MASK = 32'h5000_11B4;
  localparam logic [31:0] UFM_ADDR_QCR_VIEW = 32'h5000_11B8;

  ////////////////////////////////////////////////////////////////////////////
  // Queue control register layout.
  localparam int UFM_QCR_W = 8;
  localparam int UFM_QCR_FE_BIT = 0;
  localparam int UFM_QCR_DMAM_BIT = 3;
  localparam int UFM_QCR_RT_LSB = 6;
  localparam int UFM_QCR_RT_MSB = 7;
  localparam logic [7:0] UFM_QCR_RESET = 8'h00;

  // Mirror register width and mirror field positions.
  localparam int UFM_REG_W = 16;
  localparam int UFM_MIR_BIT = 0;
  localparam int UFM_RT_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Receive trigger encodings.
  localparam logic [1:0] UFM_TRIG_ONE = 2'h0;
  localparam logic [1:0] UFM_TRIG_QUARTER = 2'h1;
  localparam logic [1:0] UFM_TRIG_HALF = 2'h2;
  localparam logic [1:0] UFM_TRIG_TWO_LESS = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask layout.
  localparam int UFM_IRQ_W = 2;
  localparam int UFM_IRQ_RX_BIT = 0;
  localparam int UFM_IRQ_QRST_BIT = 1;
  localparam logic [1:0] UFM_IRQ_RESET = 2'h0;

  // DMA signalling modes.
  localparam logic UFM_DMA_MODE0 = 1'b0;
  localparam logic UFM_DMA_MODE1 = 1'b1;

endpackage

// ==== hdl/ufm_rx_trigger.sv ====
/*
 * Receive trigger comparator: turns the two-bit trigger select and the
 * receive queue fill level into a threshold-reached flag.
 * Assumes the level comes from logic on the same clock.
 */
`timescale 1ns/100ps
module ufm_rx_trigger #(
  parameter int DEPTH = 16,
  parameter int LW = $clog2(DEPTH) + 1
) (
  // Queue state
  input wire logic [LW-1:0] level,
  input wire logic [1:0] trig_sel,
  // Result
  output logic hit
);

  logic [LW-1:0] thr;

  always_comb begin
    case (trig_sel)
      ufm_pkg::UFM_TRIG_ONE: thr = LW'(1);
      ufm_pkg::UFM_TRIG_QUARTER: thr = LW'(DEPTH / 4);
      ufm_pkg::UFM_TRIG_HALF: thr = LW'(DEPTH / 2);
      ufm_pkg::UFM_TRIG_TWO_LESS: thr = LW'(DEPTH - 2);
      default: thr = LW'(1);
    endcase
  end

  assign hit = (level >= thr);

endmodule

// ==== testbench/ufm_mirror_top_tb_top.sv ====
/*
 * Self-checking bench for the queue control mirror block: APB tasks,
 * directed tests and a queue level model on the far side.
 * Assumes DEPTH 16, so the trigger levels are 1, 4, 8 and 14.
 */
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module ufm_mirror_top_tb_top;
  localparam int LW = 5;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [LW-1:0] tx_level, rx_level;
  logic [LW-1:0] set_tx = '0;
  logic [LW-1:0] set_rx = '0;
  logic set_en = 1'b0;
  logic [7:0] queue_control;
  logic tx_queue_enable, rx_queue_enable, queue_reset, rx_data_avail;
  logic dma_tx_req_n, dma_rx_req_n, irq;
  logic [31:0] rd;
  logic err;
  logic [4:0] thr [4] = '{5'd1, 5'd4, 5'd8, 5'd14};
  logic [31:0] regs [6];
  int fails = 0;
  int compares = 0;

  always #50 pclk = ~pclk;

  ufm_mirror_top #(.DEPTH(16)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_level(tx_level), .rx_level(rx_level),
    .queue_control(queue_control), .tx_queue_enable(tx_queue_enable),
    .rx_queue_enable(rx_queue_enable), .queue_reset(queue_reset),
    .rx_data_avail(rx_data_avail), .dma_tx_req_n(dma_tx_req_n),
    .dma_rx_req_n(dma_rx_req_n), .irq(irq));

  ufm_queue_model #(.LW(LW)) queues (.pclk(pclk), .presetn(presetn),
    .set_en(set_en), .set_tx(set_tx), .set_rx(set_rx),
    .queue_reset(queue_reset), .tx_level(tx_level), .rx_level(rx_level));

  //////////////////////////////////////////////////////////////////////////
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // Levels pass the model and then one register stage in the block.
  task automatic set_lv(input logic [LW-1:0] t, input logic [LW-1:0] r);
    @(posedge pclk);
    set_en <= 1'b1;
    set_tx <= t;
    set_rx <= r;
    @(posedge pclk);
    set_en <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The tests take well under a thousand cycles.
  initial begin
    #2_000_000;
    fails++;
    end_of_test();
  end

  initial begin
    regs = '{ufm_pkg::UFM_ADDR_DMA_MODE, ufm_pkg::UFM_ADDR_Q_ENABLE,
      ufm_pkg::UFM_ADDR_RX_THR, ufm_pkg::UFM_ADDR_IRQ_STAT,
      ufm_pkg::UFM_ADDR_IRQ_MASK, ufm_pkg::UFM_ADDR_QCR_VIEW};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK(queue_control, 8'h00)
    `CHK(dma_tx_req_n, 1'b1)
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, regs[i], 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    $display("test reset values done");
    apb(1'b1, ufm_pkg::UFM_ADDR_DMA_MODE, 32'hFFFF_FFFF);
    `CHK(queue_control, 8'h08)
    `CHK(pready, 1'b0)
    apb(1'b0, ufm_pkg::UFM_ADDR_DMA_MODE, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    apb(1'b1, ufm_pkg::UFM_ADDR_Q_ENABLE, 32'h0000_0001);
    `CHK(queue_control, 8'h09)
    `CHK({tx_queue_enable, rx_queue_enable}, 2'b11)
    $display("test mode and enable done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ufm_pkg::UFM_ADDR_RX_THR, 32'h0000_FFFC | i);
      `CHK(queue_control, {i[1:0], 6'h09})
      apb(1'b0, ufm_pkg::UFM_ADDR_QCR_VIEW, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, i[1:0], 6'h09})
      set_lv(5'd3, thr[i] - 5'd1);
      `CHK({rx_data_avail, dma_rx_req_n}, 2'b01)
      set_lv(5'd3, thr[i]);
      `CHK(rx_data_avail, 1'b1)
      `CHK(dma_rx_req_n, 1'b0)
      `CHK(dma_tx_req_n, 1'b0)
      set_lv(5'd0, 5'd0);
    end
    set_lv(5'd16, 5'd0);
    `CHK(dma_tx_req_n, 1'b1)
    $display("test thresholds done");
    apb(1'b1, ufm_pkg::UFM_ADDR_DMA_MODE, 32'h0000_0000);
    `CHK(queue_control, 8'hC1)
    set_lv(5'd3, 5'd1);
    `CHK({dma_tx_req_n, dma_rx_req_n}, 2'b10)
    set_lv(5'd0, 5'd0);
    `CHK({dma_tx_req_n, dma_rx_req_n}, 2'b01)
    $display("test mode zero done");
    apb(1'b0, ufm_pkg::UFM_ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    `CHK(irq, 1'b0)
    apb(1'b1, ufm_pkg::UFM_ADDR_IRQ_MASK, 32'h0000_0003);
    @(posedge pclk);
    #1;
    `CHK(irq, 1'b1)
    apb(1'b1, ufm_pkg::UFM_ADDR_IRQ_STAT, 32'h0000_0001);
    @(posedge pclk);
    #1;
    `CHK(irq, 1'b0)
    set_lv(5'd5, 5'd0);
    `CHK(dma_tx_req_n, 1'b1)
    apb(1'b1, ufm_pkg::UFM_ADDR_Q_ENABLE, 32'h0000_0000);
    `CHK(queue_reset, 1'b1)
    `CHK(queue_control, 8'hC0)
    `CHK({tx_queue_enable, rx_queue_enable}, 2'b00)
    @(posedge pclk);
    #1;
    `CHK(queue_reset, 1'b0)
    repeat (2) @(posedge pclk);
    #1;
    `CHK(dma_tx_req_n, 1'b0)
    `CHK(irq, 1'b1)
    apb(1'b0, ufm_pkg::UFM_ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002)
    apb(1'b1, ufm_pkg::UFM_ADDR_IRQ_STAT, 32'h0000_0002);
    @(posedge pclk);
    #1;
    `CHK(irq, 1'b0)
    $display("test interrupt and queue reset done");
    apb(1'b0, 32'h5000_11A0, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, 32'h5000_11A0, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    `CHK(queue_control, 8'hC0)
    $display("test unmapped address done");
    end_of_test();
  end
endmodule

// ==== testbench/ufm_queue_model.sv ====
/*
 * Behavioural model of the queue side: holds the transmit and receive
 * fill levels that the bench asks for and empties both on queue reset.
 * Assumes the bench loads levels through set_en on pclk.
 */
`timescale 1ns/100ps
module ufm_queue_model #(
  parameter int LW = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic set_en,
  input wire logic [LW-1:0] set_tx,
  input wire logic [LW-1:0] set_rx,
  // Device side
  input wire logic queue_reset,
  output logic [LW-1:0] tx_level,
  output logic [LW-1:0] rx_level
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_level <= '0;
      rx_level <= '0;
    end else if (queue_reset) begin
      tx_level <= '0;
      rx_level <= '0;
    end else if (set_en) begin
      tx_level <= set_tx;
      rx_level <= set_rx;
    end
  end
endmodule
